/* tb/bbfhc_flash_model.sv */
`timescale 1ns/1ps
// ****************************************
// flash device model as seen at its pins, bottom boot layout
// ****************************************
module bbfhc_flash_model #(
    parameter int ACC_NS = 70, // read access delay
    parameter logic [15:0] MAKER_ID = 16'h225A, // arbitrary value
    parameter logic [15:0] DEV_ID = 16'h113C // arbitrary value
)(
    input wire logic rstPwdN, // reset pin
    input wire logic unlockHv, // reset pin at unlock voltage
    input wire logic idVolt, // A9 at identifier voltage
    input wire logic ceN, // chip enable
    input wire logic oeN, // output enable
    input wire logic weN, // write enable
    input wire logic wpPin, // write protect
    input wire logic byteN, // byte select
    input wire logic [18:0] addr, // address pins
    input wire logic [15:0] dq, // resolved data pins
    output logic [15:0] devDq, // data driven by device
    output logic [15:0] devOe // per-pin drive enable
);
    logic [7:0] mem [int]; // programmed bytes, absent means erased
    int ks [$]; // keys of an erased block
    logic [1:0] pend; // 1 erase setup, 2 program setup
    logic arrayMode; // reads return array data
    logic [7:0] stat; // status byte
    logic [15:0] rdVal; // value to drive
    int ba; // byte address of a write
    int rb; // byte address of a read
    // block index of a byte address, block 0 is the boot block
    function automatic int blockOf(int b);
        if (b < 'h4000) return 0;
        if (b < 'h6000) return 1;
        if (b < 'h8000) return 2;
        if (b < 'h20000) return 3;
        return 4 + (b >> 17);
    endfunction
    function automatic logic [7:0] rdByte(int b);
        return mem.exists(b) ? mem[b] : 8'hFF;
    endfunction
    // program only clears bits
    task automatic prog(int b, logic [7:0] d);
        mem[b] = rdByte(b) & d;
    endtask
    // reset pin low returns to array read
    always @(rstPwdN) begin
        if (!rstPwdN) begin
            pend = 2'd0;
            arrayMode = 1'b1;
            stat = 8'h80;
        end
    end
    // command and data latched on the write strobe rising edge
    always @(posedge weN) begin
        if (rstPwdN && !ceN) begin
            ba = byteN ? int'({addr, 1'b0}) : int'({addr, dq[15]});
            if (pend == 2'd2) begin
                if (blockOf(ba) != 0 || unlockHv || wpPin) begin
                    prog(ba, dq[7:0]);
                    if (byteN) prog(ba + 1, dq[15:8]);
                end else stat = 8'h90;
                pend = 2'd0;
                arrayMode = 1'b0;
            end else if (pend == 2'd1 && dq[7:0] == 8'hD0) begin
                if (blockOf(ba) != 0 || unlockHv || wpPin) begin
                    ks.delete();
                    foreach (mem[k]) if (blockOf(k) == blockOf(ba)) ks.push_back(k);
                    foreach (ks[i]) mem.delete(ks[i]);
                end else stat = 8'hA0;
                pend = 2'd0;
                arrayMode = 1'b0;
            end else begin
                pend = (dq[7:0] == 8'h20) ? 2'd1 : (dq[7:0] == 8'h10 || dq[7:0] == 8'h40) ? 2'd2 : 2'd0;
                if (dq[7:0] == 8'hFF) arrayMode = 1'b1;
            end
        end
    end
    // read data path and drive enables
    always @* begin
        rb = byteN ? int'({addr, 1'b0}) : int'({addr, dq[15]});
        if (idVolt) rdVal = addr[0] ? DEV_ID : MAKER_ID;
        else if (arrayMode) rdVal = {rdByte(rb + 1), rdByte(rb)};
        else rdVal = {8'h00, stat};
        if (rstPwdN && !ceN && !oeN && weN) devOe = byteN ? 16'hFFFF : 16'h00FF;
        else devOe = 16'h0000;
    end
    assign #(ACC_NS) devDq = rdVal;
endmodule

/* tb/boot_block_flash_bus_decode_bench.sv */
`timescale 1ns/1ps
// ****************************************
// bench: host controller against the device model
// ****************************************
module boot_block_flash_bus_decode_bench;
    import bbfhc_pkg::*;
    localparam logic [15:0] MAKER = 16'h225A; // arbitrary value
    localparam logic [15:0] DEV = 16'h113C; // arbitrary value
    logic clk_sys, srst, reqValid, reqWide, reqBoot, reqUnlockHv, reqReady, rspValid, flt;
    logic rstPwdN, unlockHvEn, idVoltEn, ceN, oeN, weN, wpPin, byteN;
    logic [2:0] reqOp;
    logic [19:0] reqAddr;
    logic [18:0] addrOut;
    logic [15:0] reqData, rspData, dqOut, dqOe, devDq, devOe, busDq, rd;
    int errors, samples_checked;
    // undriven lines toggle so stale values never pass
    assign busDq = (dqOe & dqOut) | (~dqOe & devOe & devDq) | (~dqOe & ~devOe & {16{flt}});
    bbfhc_host u_bbfhc_host (.clk_sys(clk_sys), .srst(srst), .reqValid(reqValid), .reqOp(reqOp),
        .reqAddr(reqAddr), .reqData(reqData), .reqWide(reqWide), .reqBoot(reqBoot),
        .reqUnlockHv(reqUnlockHv), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
        .rstPwdN(rstPwdN), .unlockHvEn(unlockHvEn), .idVoltEn(idVoltEn), .ceN(ceN), .oeN(oeN),
        .weN(weN), .wpPin(wpPin), .byteN(byteN), .addrOut(addrOut), .dqOut(dqOut), .dqOe(dqOe),
        .dqIn(busDq));
    bbfhc_flash_model #(.ACC_NS(70), .MAKER_ID(MAKER), .DEV_ID(DEV)) u_bbfhc_flash_model (
        .rstPwdN(rstPwdN), .unlockHv(unlockHvEn), .idVolt(idVoltEn), .ceN(ceN), .oeN(oeN),
        .weN(weN), .wpPin(wpPin), .byteN(byteN), .addr(addrOut), .dq(busDq), .devDq(devDq),
        .devOe(devOe));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) flt <= ~flt;
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one request, waits for its answer pulse
    task automatic doOp(logic [2:0] op, logic [19:0] a, logic [15:0] d, logic w, logic b, logic hv);
        int n;
        @(negedge clk_sys);
        reqValid = 1'b1;
        reqOp = op;
        reqAddr = a;
        reqData = d;
        reqWide = w;
        reqBoot = b;
        reqUnlockHv = hv;
        n = 0;
        while (reqReady !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        reqValid = 1'b0;
        n = 0;
        while (rspValid !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("answer", {15'h0000, rspValid}, 16'h0001);
        rd = rspData;
    endtask
    // pin watch: no contention, upper lines quiet in byte writes
    always @(negedge clk_sys) begin
        if (!srst && !ceN && !oeN) check("host drive in read", dqOe, {!byteN, 15'h0000});
        if (!srst && !weN && !byteN) check("upper lines", {9'h000, dqOe[14:8]}, 16'h0000);
    end
    task automatic t_program;
        doOp(OP_READ, 20'h10000, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("erased word", rd, 16'hFFFF);
        doOp(OP_PROGRAM, 20'h10000, 16'h1234, 1'b1, 1'b0, 1'b0);
        doOp(OP_READ, 20'h10000, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("status after program", rd, 16'h0080);
        doOp(OP_READ_ARRAY, 20'h10000, 16'h0000, 1'b1, 1'b0, 1'b0);
        doOp(OP_READ, 20'h10000, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("word program", rd, 16'h1234);
    endtask
    task automatic t_byte;
        doOp(OP_PROGRAM, 20'h40001, 16'h0056, 1'b0, 1'b0, 1'b0);
        doOp(OP_READ_ARRAY, 20'h40001, 16'h0000, 1'b0, 1'b0, 1'b0);
        doOp(OP_READ, 20'h40001, 16'h0000, 1'b0, 1'b0, 1'b0);
        check("byte read", {8'h00, rd[7:0]}, 16'h0056);
        doOp(OP_READ, 20'h20000, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("word of byte pair", rd, 16'h56FF);
    endtask
    task automatic t_boot;
        doOp(OP_PROGRAM, 20'h00010, 16'h00F0, 1'b1, 1'b1, 1'b1);
        doOp(OP_PROGRAM, 20'h00011, 16'h0000, 1'b1, 1'b0, 1'b0);
        doOp(OP_PROGRAM, 20'h00012, 16'h0F0F, 1'b1, 1'b1, 1'b0);
        doOp(OP_READ_ARRAY, 20'h00000, 16'h0000, 1'b1, 1'b0, 1'b0);
        doOp(OP_READ, 20'h00010, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("boot via unlock voltage", rd, 16'h00F0);
        doOp(OP_READ, 20'h00011, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("boot locked", rd, 16'hFFFF);
        doOp(OP_READ, 20'h00012, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("boot via protect pin", rd, 16'h0F0F);
    endtask
    task automatic t_erase;
        doOp(OP_ERASE, 20'h10000, 16'h0000, 1'b1, 1'b0, 1'b0);
        doOp(OP_READ_ARRAY, 20'h10000, 16'h0000, 1'b1, 1'b0, 1'b0);
        doOp(OP_READ, 20'h10000, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("erased block", rd, 16'hFFFF);
        doOp(OP_READ, 20'h20000, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("other block kept", rd, 16'h56FF);
    endtask
    task automatic t_ident_reset;
        doOp(OP_IDENT, 20'h00000, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("maker code", rd, MAKER);
        doOp(OP_IDENT, 20'h7FF01, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("device code", rd, DEV);
        doOp(OP_PROGRAM, 20'h30000, 16'hABCD, 1'b1, 1'b0, 1'b0);
        doOp(OP_RESET, 20'h00000, 16'h0000, 1'b1, 1'b0, 1'b0);
        doOp(OP_READ, 20'h30000, 16'h0000, 1'b1, 1'b0, 1'b0);
        check("array after reset", rd, 16'hABCD);
        doOp(3'h6, 20'h00000, 16'h0000, 1'b1, 1'b0, 1'b0);
    endtask
    initial begin
        errors = 0;
        samples_checked = 0;
        flt = 1'b0;
        srst = 1'b1;
        {reqValid, reqWide, reqBoot, reqUnlockHv} = 4'h0;
        reqOp = 3'h0;
        reqAddr = 20'h00000;
        reqData = 16'h0000;
        repeat (4) @(negedge clk_sys);
        srst = 1'b0;
        repeat (2) @(negedge clk_sys);
        t_program;
        t_byte;
        t_boot;
        t_erase;
        t_ident_reset;
        end_sim;
    end
    // watchdog well beyond the expected run length
    initial begin
        #300000;
        errors++;
        end_sim;
    end
endmodule

/* verilog/bbfhc_cyc_if.sv */
`timescale 1ns/1ps
// ****************************************
// one bus cycle request between sequencer and cycle timer
// ****************************************
interface bbfhc_cyc_if;
    logic start; // begin one bus cycle
    logic isWrite; // write cycle, else read
    logic done; // one-cycle pulse at end
    logic [15:0] rdData; // captured read data
    modport seq (output start, output isWrite, input done, input rdData);
    modport tim (input start, input isWrite, output done, output rdData);
endinterface

/* verilog/bbfhc_cycle_timer.sv */
`timescale 1ns/1ps
// ****************************************
// strobe timer: shapes one write or read cycle on the pins
// ****************************************
module bbfhc_cycle_timer
    import bbfhc_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset
    bbfhc_cyc_if.tim cyc, // request from sequencer
    input wire logic [15:0] dqInSync, // synchronised data pins
    output logic chipEnableN, // chip enable to pin logic
    output logic outEnableN, // output enable to pin logic
    output logic writeEnableN // write enable to pin logic
);
    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_SETUP = 2'b01,
        T_STROBE = 2'b10,
        T_HOLD = 2'b11
    } bbfhc_tstate_t;

    bbfhc_tstate_t state_q, state_d; // timer state
    logic [7:0] cnt_q, cnt_d; // phase counter
    logic wr_q, wr_d; // current cycle is a write
    logic [15:0] rd_q, rd_d; // captured read data
    logic done_q, done_d; // end-of-cycle pulse

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        wr_d = wr_q;
        rd_d = rd_q;
        done_d = 1'b0;
        case (state_q)
            T_IDLE: begin
                // chip enable falls first, strobe follows after setup
                if (cyc.start) begin
                    wr_d = cyc.isWrite;
                    cnt_d = SETUP_CYC;
                    state_d = T_SETUP;
                end
            end
            T_SETUP: begin
                if (cnt_q <= 8'h01) begin
                    cnt_d = wr_q ? STROBE_CYC : ACCESS_CYC;
                    state_d = T_STROBE;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            T_STROBE: begin
                if (cnt_q <= 8'h01) begin
                    // sample data at the end of access time
                    if (!wr_q) begin
                        rd_d = dqInSync;
                    end
                    cnt_d = HOLD_CYC;
                    state_d = T_HOLD;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            T_HOLD: begin
                if (cnt_q <= 8'h01) begin
                    done_d = 1'b1;
                    state_d = T_IDLE;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: begin
                state_d = T_IDLE;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= T_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= DATA_RST;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            done_q <= done_d;
        end
    end

    // pin levels decoded from timer state
    // write strobe rises while chip enable is still low
    assign chipEnableN = (state_q == T_IDLE);
    assign writeEnableN = !(wr_q && state_q == T_STROBE);
    assign outEnableN = !(!wr_q && state_q == T_STROBE);
    assign cyc.done = done_q;
    assign cyc.rdData = rd_q;
endmodule

/* verilog/bbfhc_host.sv */
`timescale 1ns/1ps
// ****************************************
// host controller driving a boot-block flash over its pins
// ****************************************
module bbfhc_host
    import bbfhc_pkg::*;
#(
    parameter int ADDR_W = 20 // address width incl. low byte address
)(
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset
    input wire logic reqValid, // command request
    input wire logic [2:0] reqOp, // operation code
    input wire logic [ADDR_W-1:0] reqAddr, // byte or word address
    input wire logic [15:0] reqData, // program data
    input wire logic reqWide, // word mode, else byte mode
    input wire logic reqBoot, // target is the boot block
    input wire logic reqUnlockHv, // use unlock voltage, else protect pin
    output logic reqReady, // idle, may take request
    output logic rspValid, // one-cycle answer pulse
    output logic [15:0] rspData, // read data
    output logic rstPwdN, // reset_powerdown_n pin level
    output logic unlockHvEn, // raise reset pin to unlock_high_voltage
    output logic idVoltEn, // raise A9 to identifier_voltage
    output logic ceN, // chip enable, active low
    output logic oeN, // output enable, active low
    output logic weN, // write enable, active low
    output logic wpPin, // write protect level
    output logic byteN, // byte select, low for byte mode
    output logic [ADDR_W-2:0] addrOut, // address pins A0 upward
    output logic [15:0] dqOut, // data pins out; bit 15 is top_data_or_low_addr
    output logic [15:0] dqOe, // per-pin output enable
    input wire logic [15:0] dqIn // data pins in
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_CMD1 = 3'b001,
        S_CMD2 = 3'b010,
        S_READ = 3'b011,
        S_RESET = 3'b100,
        S_DONE = 3'b101
    } bbfhc_state_t;

    bbfhc_cyc_if cyc(); // link to cycle timer
    logic [15:0] dqMeta_q, dqSync_q; // data pin synchroniser
    logic ceW, oeW, weW; // strobes from timer
    bbfhc_state_t state_q, state_d; // sequencer state
    logic [2:0] op_q, op_d; // latched operation
    logic [ADDR_W-1:0] addr_q, addr_d; // latched address
    logic [15:0] data_q, data_d; // latched data
    logic wide_q, wide_d; // latched width
    logic boot_q, boot_d; // latched boot target
    logic hv_q, hv_d; // latched unlock method
    logic [7:0] cnt_q, cnt_d; // reset counter
    logic start_q, start_d; // cycle start pulse
    logic isWr_q, isWr_d; // cycle direction
    logic [15:0] rsp_q, rsp_d; // answer data
    logic rv_q, rv_d; // answer pulse
    logic id_q, id_d; // identifier voltage on A9

    // ****************************************
    // pin synchroniser: first stage read only by second
    // ****************************************
    always_ff @(posedge clk_sys) begin
        dqMeta_q <= dqIn;
        dqSync_q <= dqMeta_q;
    end

    bbfhc_cycle_timer u_timer (
        .clk_sys(clk_sys),
        .srst(srst),
        .cyc(cyc.tim),
        .dqInSync(dqSync_q),
        .chipEnableN(ceW),
        .outEnableN(oeW),
        .writeEnableN(weW)
    );

    assign cyc.start = start_q;
    assign cyc.isWrite = isWr_q;

    // byte in the command lanes for a code
    function automatic logic [15:0] cmd_word(input logic [7:0] c);
        cmd_word = {8'h00, c}; // only low lanes carry commands
    endfunction

    // ****************************************
    // sequencer next state
    // ****************************************
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        addr_d = addr_q;
        data_d = data_q;
        wide_d = wide_q;
        boot_d = boot_q;
        hv_d = hv_q;
        cnt_d = cnt_q;
        start_d = 1'b0;
        isWr_d = isWr_q;
        rsp_d = rsp_q;
        rv_d = 1'b0;
        id_d = id_q;
        case (state_q)
            S_IDLE: begin
                if (reqValid) begin
                    op_d = reqOp;
                    // identification clears all but the two lowest request address bits
                    addr_d = (reqOp == OP_IDENT) ? {{(ADDR_W-2){1'b0}}, reqAddr[1:0]} : reqAddr;
                    data_d = reqData;
                    wide_d = reqWide;
                    boot_d = reqBoot;
                    hv_d = reqUnlockHv;
                    case (reqOp)
                        OP_ERASE, OP_PROGRAM, OP_READ_ARRAY: begin
                            // every change goes through a command write
                            start_d = 1'b1;
                            isWr_d = 1'b1;
                            state_d = S_CMD1;
                        end
                        OP_READ, OP_IDENT: begin
                            id_d = (reqOp == OP_IDENT);
                            start_d = 1'b1;
                            isWr_d = 1'b0;
                            state_d = S_READ;
                        end
                        OP_RESET: begin
                            cnt_d = RESET_CYC;
                            state_d = S_RESET;
                        end
                        default: begin
                            rv_d = 1'b1;
                            state_d = S_IDLE;
                        end
                    endcase
                end
            end
            S_CMD1: begin
                // second cycle follows the setup directly
                if (cyc.done) begin
                    if (op_q == OP_READ_ARRAY) begin
                        state_d = S_DONE;
                    end else begin
                        start_d = 1'b1;
                        isWr_d = 1'b1;
                        state_d = S_CMD2;
                    end
                end
            end
            S_CMD2: begin
                // the device runs the algorithm itself
                if (cyc.done) begin
                    state_d = S_DONE;
                end
            end
            S_READ: begin
                if (cyc.done) begin
                    // byte mode returns only the low lanes
                    rsp_d = wide_q ? cyc.rdData : {8'h00, cyc.rdData[7:0]};
                    id_d = 1'b0;
                    state_d = S_DONE;
                end
            end
            S_RESET: begin
                if (cnt_q <= 8'h01) begin
                    state_d = S_DONE;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            S_DONE: begin
                rv_d = 1'b1;
                state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= S_IDLE;
            op_q <= OP_READ;
            addr_q <= ADDR_RST[ADDR_W-1:0];
            data_q <= DATA_RST;
            wide_q <= 1'b1;
            boot_q <= 1'b0;
            hv_q <= 1'b0;
            cnt_q <= 8'h00;
            start_q <= 1'b0;
            isWr_q <= 1'b0;
            rsp_q <= DATA_RST;
            rv_q <= 1'b0;
            id_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            addr_q <= addr_d;
            data_q <= data_d;
            wide_q <= wide_d;
            boot_q <= boot_d;
            hv_q <= hv_d;
            cnt_q <= cnt_d;
            start_q <= start_d;
            isWr_q <= isWr_d;
            rsp_q <= rsp_d;
            rv_q <= rv_d;
            id_q <= id_d;
        end
    end

    // ****************************************
    // pin drive, each output from a flip-flop
    // ****************************************
    logic [15:0] dqOut_d, dqOe_d; // next data pin drive
    logic unlock_d, wp_d; // next protect levels

    always_comb begin
        dqOut_d = DATA_RST;
        dqOe_d = 16'h0000;
        // low address bit rides on the top data pin in byte mode
        if (!wide_q) begin
            dqOut_d[15] = addr_q[0];
            dqOe_d[15] = 1'b1;
        end
        if (isWr_q && state_q != S_IDLE) begin
            if (state_q == S_CMD1) begin
                case (op_q)
                    OP_ERASE: dqOut_d[7:0] = CMD_ERASE_SETUP[7:0];
                    OP_PROGRAM: dqOut_d[7:0] = CMD_PROG_SETUP[7:0];
                    default: dqOut_d[7:0] = 8'(cmd_word(CMD_READ_ARRAY));
                endcase
                dqOe_d[7:0] = 8'hFF;
            end else if (op_q == OP_ERASE) begin
                dqOut_d[7:0] = 8'(cmd_word(CMD_ERASE_CONFIRM));
                dqOe_d[7:0] = 8'hFF;
            end else if (wide_q) begin
                dqOut_d = data_q;
                dqOe_d = 16'hFFFF;
            end else begin
                dqOut_d[7:0] = data_q[7:0];
                dqOe_d[7:0] = 8'hFF;
            end
        end
        // boot block unlock held through the second cycle
        unlock_d = boot_q && hv_q && (state_q == S_CMD1 || state_q == S_CMD2);
        wp_d = boot_q && !hv_q && (state_q == S_CMD1 || state_q == S_CMD2);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ceN <= 1'b1;
            oeN <= 1'b1;
            weN <= 1'b1;
            rstPwdN <= 1'b0;
            unlockHvEn <= 1'b0;
            idVoltEn <= 1'b0;
            wpPin <= 1'b0;
            byteN <= 1'b1;
            addrOut <= '0;
            dqOut <= DATA_RST;
            dqOe <= 16'h0000;
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspData <= DATA_RST;
        end else begin
            // bus idle is standby; reset pin low in reset state
            ceN <= ceW;
            oeN <= oeW;
            weN <= weW;
            rstPwdN <= (state_q != S_RESET);
            unlockHvEn <= unlock_d;
            idVoltEn <= id_q;
            wpPin <= wp_d;
            byteN <= wide_q;
            addrOut <= wide_q ? addr_q[ADDR_W-2:0] : addr_q[ADDR_W-1:1];
            dqOut <= dqOut_d;
            dqOe <= dqOe_d;
            reqReady <= (state_d == S_IDLE) && !(reqValid && state_q == S_IDLE);
            rspValid <= rv_q;
            rspData <= rsp_q;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_no_drive_on_read;
        @(posedge clk_sys) disable iff (srst) !oeN |-> dqOe[7:0] == 8'h00;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("data driven while reading");

    sequence s_setup;
        state_q == S_CMD1 && cyc.done;
    endsequence
    property p_two_cycle;
        @(posedge clk_sys) disable iff (srst) (s_setup and (op_q != OP_READ_ARRAY)) |=> start_q && state_q == S_CMD2;
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("second cycle not issued");

    property p_prog_setup;
        @(posedge clk_sys) disable iff (srst) !weN && state_q == S_CMD1 && op_q == OP_PROGRAM
            |-> dqOut[7:0] == CMD_PROG_SETUP;
    endproperty
    a_prog_setup: assert property (p_prog_setup) else $error("wrong program setup");

    property p_unlock;
        @(posedge clk_sys) disable iff (srst) state_q == S_CMD2 && boot_q ##1 1'b1 |-> unlockHvEn || wpPin;
    endproperty
    a_unlock: assert property (p_unlock) else $error("boot block not unlocked");

    property p_byte_lanes;
        @(posedge clk_sys) disable iff (srst) byteN == 1'b0 |-> dqOe[14:8] == 7'h00;
    endproperty
    a_byte_lanes: assert property (p_byte_lanes) else $error("upper lanes driven in byte mode");

    property p_ident;
        @(posedge clk_sys) disable iff (srst) idVoltEn && byteN |-> addrOut[ADDR_W-2:1] == '0;
    endproperty
    a_ident: assert property (p_ident) else $error("address not held low in ident");

    property p_reset_pin;
        @(posedge clk_sys) disable iff (srst) state_q == S_RESET |=> !rstPwdN && ceN;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("reset pin not low");

    property p_top_pin;
        @(posedge clk_sys) disable iff (srst) !byteN |-> dqOe[15] && dqOut[15] == $past(addr_q[0]);
    endproperty
    a_top_pin: assert property (p_top_pin) else $error("low address bit wrong");

    property p_strobe_ce;
        @(posedge clk_sys) disable iff (srst) $rose(weN) |-> !ceN;
    endproperty
    a_strobe_ce: assert property (p_strobe_ce) else $error("write strobe rose without chip enable");
endmodule

/* verilog/bbfhc_pkg.sv */
package bbfhc_pkg;
    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    // ****************************************
    // operation codes of the host command port
    // ****************************************
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_ERASE = 3'h1;
    localparam logic [2:0] OP_PROGRAM = 3'h2;
    localparam logic [2:0] OP_READ_ARRAY = 3'h3;
    localparam logic [2:0] OP_IDENT = 3'h4;
    localparam logic [2:0] OP_RESET = 3'h5;
    // ****************************************
    // bus timing in ns and cycles at 100 MHz
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS = 20;
    localparam int STROBE_NS = 50;
    localparam int ACCESS_NS = 80;
    localparam int HOLD_NS = 20;
    localparam int RESET_NS = 100;
    localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] ACCESS_CYC = 8'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
    localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RESET_CYC = 8'((RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ****************************************
    // reset values of the pins
    // ****************************************
    localparam logic [19:0] ADDR_RST = 20'h00000;
    localparam logic [15:0] DATA_RST = 16'h0000;
endpackage
